// ---- fpc_flash_dev.sv ----
// Flash page controller: register file, sequencer, protection and flash array
`timescale 1ns/1ns
`include "fpc_map.svh"
module fpc_flash_dev
  import fpc_pkg::*;
#(
  parameter int PAGES      = 32,
  parameter int PAGE_BYTES = 512
) (
  input  wire logic clk,
  input  wire logic rst,
  fpc_sfr_if.dev    sfr,
  output logic      flash_busy
);
  localparam int DEPTH = PAGES * PAGE_BYTES;
  localparam int AW    = $clog2(DEPTH);
  localparam int PW    = $clog2(PAGE_BYTES);
  localparam int NW    = AW - PW;
  localparam logic [AW-1:0] KEY_A = AW'(DEPTH - `FPC_PKEY_FROM_END);
  localparam logic [AW-1:0] PRD_A = AW'(DEPTH - `FPC_PRD_FROM_END);
  localparam logic [AW-1:0] PWE_A = AW'(DEPTH - `FPC_PWE_FROM_END);

  logic [7:0]    mem_q [DEPTH];  // Flash array, one byte per index
  logic [7:0]    cmd_q;          // Last command written
  logic [7:0]    key_q;          // Unlock key
  logic [7:0]    pkey_q;         // Protection change key
  logic [7:0]    data_q;         // Data byte
  logic [7:0]    pwe_lo_q;       // Write/erase flags, pages 0 to 7
  logic [7:0]    pwe_hi_q;       // Write/erase flags, pages 8 to 15
  logic [7:0]    prd_q;          // Read flags per page group
  logic [7:0]    adl_q;          // Address low byte
  logic [7:0]    adh_q;          // Address high byte
  logic [7:0]    rdata_q;        // Registered read data
  logic          stall_q;        // Core stall and interrupt hold
  fpc_seq_e      seq_q;          // Sequencer state
  logic [AW-1:0] cur_q;          // Walking address for erase and protect
  logic [AW:0]   cnt_q;          // Bytes left after the current one in the walk
  logic [AW-1:0] tgt_q;          // Target address latched at start
  logic [7:0]    op_q;           // Command being executed

  logic [AW-1:0] addr;           // Address from the two registers
  logic          cmd_wr;         // Command register write
  logic          go;             // Command accepted
  logic [31:0]   we_map;         // Write/erase flags held in flash
  logic          pkey_ok;        // Protection change allowed
  logic [1:0]    pidx;           // Protection byte being committed
  logic [7:0]    pval;           // Value for that byte

  // Page number of a byte address
  function automatic logic [NW-1:0] page_of(input logic [AW-1:0] a);
    page_of = a[AW-1:PW];
  endfunction : page_of

  // Only the six defined codes start anything
  function automatic logic code_ok(input logic [7:0] c);
    code_ok = (c == `FPC_CMD_WRITE) || (c == `FPC_CMD_ERASE) || (c == `FPC_CMD_MASS) ||
              (c == `FPC_CMD_READ)  || (c == `FPC_CMD_ERWR)  || (c == `FPC_CMD_PROT);
  endfunction : code_ok

  assign addr   = AW'({adh_q, adl_q});
  assign cmd_wr = sfr.sfr_wr && (sfr.sfr_addr == `FPC_SFR_CMD);
  assign go     = cmd_wr && (seq_q == SEQ_IDLE) && (key_q == `FPC_UNLOCK_VALUE)
                  && code_ok(sfr.sfr_wdata);
  // Protection is read straight from the reserved flash bytes
  assign we_map  = {mem_q[PWE_A+3], mem_q[PWE_A+2], mem_q[PWE_A+1], mem_q[PWE_A]};
  // Blank stored key skips the comparison
  assign pkey_ok = (mem_q[KEY_A] == `FPC_ERASED) || (mem_q[KEY_A] == pkey_q);
  assign pidx    = 2'(cur_q - KEY_A);

  // Page may be written or erased; a set flag leaves it open
  function automatic logic we_open(input logic [AW-1:0] a);
    we_open = we_map[5'(page_of(a))];
  endfunction : we_open

  // Page group may be read; four pages share one flag
  function automatic logic rd_open(input logic [AW-1:0] a);
    rd_open = mem_q[PRD_A][3'(page_of(a) >> `FPC_RD_GROUP_SHIFT)];
  endfunction : rd_open

  // Protection bytes in flash order: key, read flags, two write/erase bytes
  always_comb begin
    unique case (pidx)
      2'd0: pval = pkey_q;
      2'd1: pval = prd_q;
      2'd2: pval = pwe_lo_q;
      2'd3: pval = pwe_hi_q;
    endcase
  end

  // Plain software registers
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_q    <= `FPC_RST_CMD;
      pkey_q   <= `FPC_RST_PKEY;
      pwe_lo_q <= `FPC_RST_PROT;
      pwe_hi_q <= `FPC_RST_PROT;
      prd_q    <= `FPC_RST_PROT;
      adl_q    <= `FPC_RST_ADDR;
      adh_q    <= `FPC_RST_ADDR;
    end else if (sfr.sfr_wr) begin
      unique case (sfr.sfr_addr)
        `FPC_SFR_CMD:     cmd_q    <= sfr.sfr_wdata;
        `FPC_SFR_PKEY:    pkey_q   <= sfr.sfr_wdata;
        `FPC_SFR_PWE_LO:  pwe_lo_q <= sfr.sfr_wdata;
        `FPC_SFR_PWE_HI:  pwe_hi_q <= sfr.sfr_wdata;
        `FPC_SFR_PRD:     prd_q    <= sfr.sfr_wdata;
        `FPC_SFR_ADDR_LO: adl_q    <= sfr.sfr_wdata;
        `FPC_SFR_ADDR_HI: adh_q    <= sfr.sfr_wdata;
        default: ;
      endcase
    end
  end

  // Unlock key; every finished operation throws it away
  always_ff @(posedge clk) begin
    if (rst) begin
      key_q <= `FPC_RST_KEY;
    end else if (sfr.sfr_wr && sfr.sfr_addr == `FPC_SFR_KEY) begin
      key_q <= sfr.sfr_wdata;
    end else if (seq_q == SEQ_DONE) begin
      key_q <= `FPC_RST_KEY;
    end
  end

  // Data byte; a read command loads it unless the group is read protected
  always_ff @(posedge clk) begin
    if (rst) begin
      data_q <= `FPC_RST_DATA;
    end else if (sfr.sfr_wr && sfr.sfr_addr == `FPC_SFR_DATA) begin
      data_q <= sfr.sfr_wdata;
    end else if (seq_q == SEQ_READ && rd_open(tgt_q)) begin
      data_q <= mem_q[tgt_q];
    end
  end

  // Sequencer: one byte per cycle while erasing, so page erase takes 512 cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      seq_q <= SEQ_IDLE;
      cur_q <= '0;
      cnt_q <= '0;
      tgt_q <= '0;
      op_q  <= `FPC_RST_CMD;
    end else begin
      unique case (seq_q)
        SEQ_IDLE: begin
          if (go) begin
            op_q  <= sfr.sfr_wdata;
            tgt_q <= addr;
            unique case (sfr.sfr_wdata)
              `FPC_CMD_WRITE: seq_q <= SEQ_PROG;
              `FPC_CMD_READ:  seq_q <= SEQ_READ;
              `FPC_CMD_MASS: begin
                seq_q <= SEQ_ERASE;
                cur_q <= '0;
                cnt_q <= (AW+1)'(DEPTH - 1);
              end
              `FPC_CMD_PROT: begin
                seq_q <= pkey_ok ? SEQ_PROT : SEQ_DONE;
                cur_q <= KEY_A;
                cnt_q <= (AW+1)'(3);
              end
              default: begin
                // Page erase, alone or before a program; any address in the page
                seq_q <= we_open(addr) ? SEQ_ERASE : SEQ_DONE;
                cur_q <= {page_of(addr), {PW{1'b0}}};
                cnt_q <= (AW+1)'(PAGE_BYTES - 1);
              end
            endcase
          end
        end
        SEQ_ERASE: begin
          cur_q <= cur_q + 1'b1;
          cnt_q <= cnt_q - 1'b1;
          if (cnt_q == '0) begin
            seq_q <= (op_q == `FPC_CMD_ERWR) ? SEQ_PROG : SEQ_DONE;
          end
        end
        SEQ_PROT: begin
          cur_q <= cur_q + 1'b1;
          cnt_q <= cnt_q - 1'b1;
          if (cnt_q == '0) begin
            seq_q <= SEQ_DONE;
          end
        end
        SEQ_PROG: seq_q <= SEQ_DONE;
        SEQ_READ: seq_q <= SEQ_DONE;
        SEQ_DONE: seq_q <= SEQ_IDLE;
      endcase
    end
  end

  // Flash array; starts erased, programming can only clear bits
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= `FPC_ERASED;
      end
    end else if (seq_q == SEQ_ERASE) begin
      mem_q[cur_q] <= `FPC_ERASED;
    end else if (seq_q == SEQ_PROG && we_open(tgt_q)) begin
      mem_q[tgt_q] <= mem_q[tgt_q] & data_q;
    end else if (seq_q == SEQ_PROT) begin
      mem_q[cur_q] <= mem_q[cur_q] & pval;
    end
  end

  // Stall covers the whole operation; it holds the core and its interrupts and drives flash_busy, while peripherals keep running
  always_ff @(posedge clk) begin
    if (rst) begin
      stall_q <= 1'b0;
    end else if (go) begin
      stall_q <= 1'b1;
    end else if (seq_q == SEQ_DONE) begin
      stall_q <= 1'b0;
    end
  end

  // Registered read port; unmapped offsets read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (sfr.sfr_rd) begin
      unique case (sfr.sfr_addr)
        `FPC_SFR_CMD:     rdata_q <= cmd_q;
        `FPC_SFR_KEY:     rdata_q <= key_q;
        `FPC_SFR_PKEY:    rdata_q <= pkey_q;
        `FPC_SFR_DATA:    rdata_q <= data_q;
        `FPC_SFR_PWE_LO:  rdata_q <= pwe_lo_q;
        `FPC_SFR_PWE_HI:  rdata_q <= pwe_hi_q;
        `FPC_SFR_PRD:     rdata_q <= prd_q;
        `FPC_SFR_ADDR_LO: rdata_q <= adl_q;
        `FPC_SFR_ADDR_HI: rdata_q <= adh_q;
        default:          rdata_q <= 8'h00;
      endcase
    end
  end

  assign sfr.sfr_rdata  = rdata_q;
  assign sfr.core_stall = stall_q;
  assign sfr.irq_hold   = stall_q;
  assign flash_busy     = stall_q;
endmodule : fpc_flash_dev

// ---- fpc_map.svh ----
// Register offsets, command codes, reset values and layout constants of the flash page controller
`ifndef FPC_MAP_SVH
`define FPC_MAP_SVH
// Special function register offsets on the core side
`define FPC_SFR_CMD      8'hb9
`define FPC_SFR_KEY      8'hba
`define FPC_SFR_PKEY     8'hbb
`define FPC_SFR_DATA     8'hbc
`define FPC_SFR_PWE_LO   8'hbd
`define FPC_SFR_PWE_HI   8'hbe
`define FPC_SFR_PRD      8'hbf
`define FPC_SFR_ADDR_LO  8'hc6
`define FPC_SFR_ADDR_HI  8'hc7
// Reset values
`define FPC_RST_CMD      8'h00
`define FPC_RST_KEY      8'hff
`define FPC_RST_PKEY     8'hff
`define FPC_RST_DATA     8'h00
`define FPC_RST_PROT     8'hff
`define FPC_RST_ADDR     8'h00
// Fixed unlock value and erased byte value
`define FPC_UNLOCK_VALUE 8'h3b
`define FPC_ERASED       8'hff
// Command codes
`define FPC_CMD_WRITE    8'h01
`define FPC_CMD_ERASE    8'h02
`define FPC_CMD_MASS     8'h03
`define FPC_CMD_READ     8'h04
`define FPC_CMD_ERWR     8'h05
`define FPC_CMD_PROT     8'h08
// Protection bytes counted back from the array end: key, read, four write/erase
`define FPC_PKEY_FROM_END 6
`define FPC_PRD_FROM_END  5
`define FPC_PWE_FROM_END  4
// Log2 of the pages covered by one read protection bit
`define FPC_RD_GROUP_SHIFT 2
// Controller registers on the Avalon side (byte addresses)
`define FPC_HR_CMD       5'h00
`define FPC_HR_ADDR      5'h04
`define FPC_HR_DATA      5'h08
`define FPC_HR_STAT      5'h0c
`define FPC_HR_RAW       5'h10
`endif

// ---- fpc_pkg.sv ----
// Types shared by both ends of the flash page controller
package fpc_pkg;
  // Device sequencer states, Gray coded along the erase-then-program path
  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b000,
    SEQ_ERASE = 3'b001,
    SEQ_PROG  = 3'b011,
    SEQ_DONE  = 3'b010,
    SEQ_READ  = 3'b110,
    SEQ_PROT  = 3'b100
  } fpc_seq_e;
  // Core-side sequence states, Gray coded along the command path
  typedef enum logic [3:0] {
    H_IDLE = 4'b0000,
    H_KEY  = 4'b0001,
    H_ADL  = 4'b0011,
    H_ADH  = 4'b0010,
    H_DAT  = 4'b0110,
    H_CMD  = 4'b0111,
    H_WAIT = 4'b0101,
    H_RD   = 4'b0100,
    H_CAP  = 4'b1100,
    H_RAW  = 4'b1000
  } fpc_host_e;
endpackage : fpc_pkg

// ---- fpc_sfr_if.sv ----
// Special function register link between the processor core and the flash controller
`timescale 1ns/1ns
interface fpc_sfr_if (
  input wire logic clk
);
  logic [7:0] sfr_addr;   // Register offset
  logic       sfr_wr;     // Write strobe
  logic       sfr_rd;     // Read strobe
  logic [7:0] sfr_wdata;  // Write data
  logic [7:0] sfr_rdata;  // Read data, one cycle after the strobe
  logic       core_stall; // Core held on the command write
  logic       irq_hold;   // Interrupt service deferred
  modport dev  (input clk, sfr_addr, sfr_wr, sfr_rd, sfr_wdata,
                output sfr_rdata, core_stall, irq_hold);
  modport core (input clk, sfr_rdata, core_stall, irq_hold,
                output sfr_addr, sfr_wr, sfr_rd, sfr_wdata);
endinterface : fpc_sfr_if

// ---- fpc_core_host.sv ----
// Core-side end: Avalon registers turned into keyed flash command sequences
`timescale 1ns/1ns
`include "fpc_map.svh"
module fpc_core_host
  import fpc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  fpc_sfr_if.core          sfr,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        periph_irq,
  output logic             core_irq
);
  fpc_host_e   st_q;       // Sequence state
  logic        wait_q;     // Avalon waitrequest
  logic [31:0] rdd_q;      // Avalon read data
  logic [7:0]  op_q;       // Command code to issue
  logic [15:0] addr_q;     // Flash byte address
  logic [7:0]  wdat_q;     // Byte to program
  logic [7:0]  rbyte_q;    // Byte returned by the last read command
  logic [7:0]  sa_q;       // SFR address out
  logic [7:0]  sd_q;       // SFR write data out
  logic        swr_q;      // SFR write strobe out
  logic        srd_q;      // SFR read strobe out
  logic        irq_q;      // Gated interrupt
  logic        acc;        // Avalon access taken this cycle

  // Accesses wait while a sequence runs, so registers never change under it
  assign acc = (avs_read || avs_write) && wait_q && (st_q == H_IDLE);

  // Waitrequest drops for exactly one cycle per taken access
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_q <= 1'b1;
      rdd_q  <= 32'h0000_0000;
    end else begin
      wait_q <= !acc;
      if (acc && avs_read) begin
        unique case (avs_address)
          `FPC_HR_CMD:  rdd_q <= {24'h000000, op_q};
          `FPC_HR_ADDR: rdd_q <= {16'h0000, addr_q};
          `FPC_HR_DATA: rdd_q <= {24'h000000, rbyte_q};
          `FPC_HR_STAT: rdd_q <= {31'h00000000, sfr.core_stall};
          default:      rdd_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Address and data latches
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_q <= 16'h0000;
      wdat_q <= 8'h00;
    end else if (acc && avs_write) begin
      if (avs_address == `FPC_HR_ADDR) addr_q <= avs_writedata[15:0];
      if (avs_address == `FPC_HR_DATA) wdat_q <= avs_writedata[7:0];
    end
  end

  // SFR sequence: key, address, data, command, then wait out the stall
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q    <= H_IDLE;
      op_q    <= `FPC_RST_CMD;
      rbyte_q <= 8'h00;
      sa_q    <= 8'h00;
      sd_q    <= 8'h00;
      swr_q   <= 1'b0;
      srd_q   <= 1'b0;
    end else begin
      unique case (st_q)
        H_IDLE: begin
          if (acc && avs_write && avs_address == `FPC_HR_CMD) begin
            op_q  <= avs_writedata[7:0];
            st_q  <= H_KEY;
            swr_q <= 1'b1;
            sa_q  <= `FPC_SFR_KEY;
            sd_q  <= `FPC_UNLOCK_VALUE;
          end else if (acc && avs_write && avs_address == `FPC_HR_RAW) begin
            // Direct register write, used for the protection registers
            st_q  <= H_RAW;
            swr_q <= 1'b1;
            sa_q  <= avs_writedata[15:8];
            sd_q  <= avs_writedata[7:0];
          end
        end
        H_KEY: begin
          st_q <= H_ADL;
          sa_q <= `FPC_SFR_ADDR_LO;
          sd_q <= addr_q[7:0];
        end
        H_ADL: begin
          st_q <= H_ADH;
          sa_q <= `FPC_SFR_ADDR_HI;
          sd_q <= addr_q[15:8];
        end
        H_ADH: begin
          st_q <= H_DAT;
          sa_q <= `FPC_SFR_DATA;
          sd_q <= wdat_q;
        end
        H_DAT: begin
          st_q <= H_CMD;
          sa_q <= `FPC_SFR_CMD;
          sd_q <= op_q;
        end
        H_CMD: begin
          st_q  <= H_WAIT;
          swr_q <= 1'b0;
        end
        H_WAIT: begin
          // Stall is already up here if the command was taken
          if (!sfr.core_stall) begin
            st_q  <= (op_q == `FPC_CMD_READ) ? H_RD : H_IDLE;
            srd_q <= (op_q == `FPC_CMD_READ);
            sa_q  <= `FPC_SFR_DATA;
          end
        end
        H_RD: begin
          st_q  <= H_CAP;
          srd_q <= 1'b0;
        end
        H_CAP: begin
          st_q    <= H_IDLE;
          rbyte_q <= sfr.sfr_rdata;
        end
        H_RAW: begin
          st_q  <= H_IDLE;
          swr_q <= 1'b0;
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  // Interrupts reach the core only once the flash operation has ended
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= periph_irq && !sfr.irq_hold;
    end
  end

  assign sfr.sfr_addr     = sa_q;
  assign sfr.sfr_wdata    = sd_q;
  assign sfr.sfr_wr       = swr_q;
  assign sfr.sfr_rd       = srd_q;
  assign avs_readdata     = rdd_q;
  assign avs_waitrequest  = wait_q;
  assign core_irq         = irq_q;
endmodule : fpc_core_host

// ---- fpc_sfr_asserts.sv ----
// Concurrent checks on the register link between core end and flash device end
`timescale 1ns/1ns
`include "fpc_map.svh"
module fpc_sfr_asserts #(
  parameter int PAGES      = 32,
  parameter int PAGE_BYTES = 512
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       core_stall,
  input wire logic       irq_hold
);
  // Longest legal stall is a mass erase
  localparam int MAX_RUN = PAGES * PAGE_BYTES + 1;
  logic [7:0] key_q;   // Unlock key as last seen on the link
  logic       stall_q; // Stall one cycle back, to spot its end
  int         run_q;   // Cycles of the current stall
  wire        cmd_wr  = sfr_wr && (sfr_addr == `FPC_SFR_CMD);
  wire        code_ok = sfr_wdata inside {`FPC_CMD_WRITE, `FPC_CMD_ERASE, `FPC_CMD_MASS,
                                          `FPC_CMD_READ, `FPC_CMD_ERWR, `FPC_CMD_PROT};
  // Key shadow: a started operation leaves the key spent when it ends
  always_ff @(posedge clk) begin
    if (rst) begin
      key_q <= `FPC_RST_KEY;
    end else if (sfr_wr && sfr_addr == `FPC_SFR_KEY) begin
      key_q <= sfr_wdata;
    end else if (stall_q && !core_stall) begin
      key_q <= `FPC_RST_KEY;
    end
  end
  // Stall history and length counter
  always_ff @(posedge clk) begin
    stall_q <= rst ? 1'b0 : core_stall;
    run_q   <= (rst || !core_stall) ? 0 : run_q + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_irq_hold: assert property (irq_hold == core_stall)
    else $error("interrupt hold differs from stall");
  chk_stall_cause: assert property ($rose(core_stall) |-> $past(cmd_wr))
    else $error("stall began without a command write");
  chk_cmd_start: assert property (cmd_wr && code_ok && key_q == `FPC_UNLOCK_VALUE && !core_stall
    |=> core_stall)
    else $error("keyed command did not start");
  chk_spent_key: assert property (cmd_wr && key_q != `FPC_UNLOCK_VALUE && !core_stall
    |=> !core_stall)
    else $error("command started without a fresh key");
  chk_bad_code: assert property (cmd_wr && !code_ok && !core_stall |=> !core_stall)
    else $error("undefined command started");
  chk_stall_bound: assert property (run_q <= MAX_RUN)
    else $error("stall longer than a mass erase");
  chk_core_quiet: assert property (core_stall |-> !sfr_wr && !sfr_rd)
    else $error("core accessed registers while stalled");
  chk_rdata_hold: assert property (!$past(sfr_rd) |-> $stable(sfr_rdata))
    else $error("read data moved without a read");
  cov_erase: cover property (cmd_wr && sfr_wdata == `FPC_CMD_ERASE ##1 core_stall);
  cov_mass: cover property (cmd_wr && sfr_wdata == `FPC_CMD_MASS ##1 core_stall);
  cov_prot: cover property (cmd_wr && sfr_wdata == `FPC_CMD_PROT ##1 core_stall);
endmodule : fpc_sfr_asserts

// ---- testbench.sv ----
// Bench driving the core end over Avalon against a byte model of the flash
`timescale 1ns/1ns
`include "fpc_map.svh"
module testbench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        periph_irq = 1'b0;
  logic        core_irq;
  logic        flash_busy;
  logic        exp_irq_q = 1'b0;
  int          bad_count = 0;
  int          compares = 0;
  int          stall_n = 0;     // Stall cycles since the last command
  int          k;
  logic [7:0]  mem [0:16383];   // Model of the flash array
  logic [7:0]  dm;              // Model of the host data register
  logic [7:0]  pkey_m = 8'hff;  // Model of the protection registers
  logic [7:0]  plo_m = 8'hff;
  logic [7:0]  prd_m = 8'hff;
  logic [15:0] a1;
  logic [7:0]  d1, d2, d3;
  logic [15:0] rd_list [0:9] = '{16'h3ffa, 16'h3ffb, 16'h3ffc, 16'h3ffd, 16'h3ffe,
                                 16'h3fff, 16'h0210, 16'h0800, 16'h0e00, 16'h1000};
  logic [7:0]  bad_codes [0:4] = '{8'h00, 8'h06, 8'h07, 8'h09, 8'hff};
  always #2 clk = ~clk;
  fpc_sfr_if u_fpc_sfr_if (.clk(clk));
  fpc_flash_dev u_fpc_flash_dev (.clk(clk), .rst(rst), .sfr(u_fpc_sfr_if),
    .flash_busy(flash_busy));
  fpc_core_host u_fpc_core_host (.clk(clk), .rst(rst), .sfr(u_fpc_sfr_if),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .periph_irq(periph_irq), .core_irq(core_irq));
  fpc_sfr_asserts #(.PAGES(32), .PAGE_BYTES(512)) u_fpc_sfr_asserts (.clk(clk), .rst(rst),
    .sfr_addr(u_fpc_sfr_if.sfr_addr), .sfr_wr(u_fpc_sfr_if.sfr_wr),
    .sfr_rd(u_fpc_sfr_if.sfr_rd), .sfr_wdata(u_fpc_sfr_if.sfr_wdata),
    .sfr_rdata(u_fpc_sfr_if.sfr_rdata), .core_stall(u_fpc_sfr_if.core_stall),
    .irq_hold(u_fpc_sfr_if.irq_hold));
  task give_verdict;
    if (bad_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task err(input string m);
    bad_count++;
    $display("unexpected %0t %s", $time, m);
  endtask : err
  task cmp_data(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) err("data");
  endtask : cmp_data
  task cmp_len(input int got, input int exp);
    compares++;
    if (got != exp) err("stall length");
  endtask : cmp_len
  task cmp_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) err("level");
  endtask : cmp_bit
  // One Avalon access, held until waitrequest is seen low
  task av(input logic rd, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 40000) begin
        err("timeout");
        give_verdict;
      end
      @(posedge clk);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : av
  // Single register write passed straight through to the link
  task raw(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    av(1'b0, `FPC_HR_RAW, {16'h0, a, d}, q);
    case (a)
      `FPC_SFR_PKEY:   pkey_m = d;
      `FPC_SFR_PWE_LO: plo_m = d;
      `FPC_SFR_PRD:    prd_m = d;
      default: ;
    endcase
  endtask : raw
  // Full keyed command; the model predicts contents and stall length
  task run(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d);
    logic [31:0] q;
    int          p, i, len;
    logic        we, rdok;
    p = a[13:9];
    we = mem[16380 + p / 8][p % 8];
    rdok = mem[16379][p / 4];
    dm = d;
    len = -1;
    case (c)
      1: if (we) begin
        mem[a[13:0]] &= d;
        len = 2;
      end
      2, 5: if (we) begin
        for (i = 0; i < 512; i++) mem[p * 512 + i] = 8'hff;
        if (c == 5) mem[a[13:0]] = d;
        len = (c == 5) ? 514 : 513;
      end
      3: begin
        for (i = 0; i < 16384; i++) mem[i] = 8'hff;
        len = 16385;
      end
      4: if (rdok) begin
        dm = mem[a[13:0]];
        len = 2;
      end
      8: if (mem[16378] == 8'hff || mem[16378] == pkey_m) begin
        mem[16378] &= pkey_m;
        mem[16379] &= prd_m;
        mem[16380] &= plo_m;
        len = 5;
      end
      default: ;
    endcase
    av(1'b0, `FPC_HR_ADDR, {16'h0, a}, q);
    av(1'b0, `FPC_HR_DATA, {24'h0, d}, q);
    stall_n = 0;
    av(1'b0, `FPC_HR_CMD, {24'h0, c}, q);
    av(1'b1, `FPC_HR_STAT, 32'h0, q);
    cmp_data({31'h0, q[0]}, 32'h0);
    av(1'b1, `FPC_HR_ADDR, 32'h0, q);
    cmp_data(q, {16'h0, a});
    av(1'b1, `FPC_HR_CMD, 32'h0, q);
    cmp_data(q, {24'h0, c});
    if (len >= 0) cmp_len(stall_n, len);
  endtask : run
  task chk_rd(input logic [15:0] a);
    logic [31:0] q;
    run(8'h04, a, 8'h5c);
    av(1'b1, `FPC_HR_DATA, 32'h0, q);
    cmp_data(q, {24'h0, dm});
  endtask : chk_rd
  // Random interrupt traffic keeps running while the core is stalled
  always @(posedge clk) begin
    if (!rst) begin
      cmp_bit(core_irq, exp_irq_q);
      cmp_bit(flash_busy, u_fpc_sfr_if.core_stall);
    end
    exp_irq_q <= !rst && periph_irq && !u_fpc_sfr_if.irq_hold;
    periph_irq <= 1'($urandom);
    if (u_fpc_sfr_if.core_stall === 1'b1) stall_n <= stall_n + 1;
  end
  initial begin
    for (k = 0; k < 16384; k++) mem[k] = 8'hff;
    void'($urandom(32'h7f1e));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    a1 = 16'($urandom_range(16'h3bff, 0));
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    d3 = 8'($urandom);
    chk_rd(a1);
    run(8'h01, a1, d1);
    chk_rd(a1);
    run(8'h01, a1, d2);
    chk_rd(a1);
    run(8'h05, a1, d3);
    chk_rd(a1);
    run(8'h01, a1 + 16'h0200, d1);
    run(8'h02, a1 ^ 16'h0101, d2);
    chk_rd(a1);
    chk_rd(a1 + 16'h0200);
    // The refused commands below must add no stall cycles at all
    stall_n = 0;
    raw(`FPC_SFR_CMD, 8'h01);
    raw(`FPC_SFR_KEY, 8'h3c);
    raw(`FPC_SFR_CMD, 8'h01);
    for (k = 0; k < 5; k++) begin
      raw(`FPC_SFR_KEY, `FPC_UNLOCK_VALUE);
      raw(`FPC_SFR_CMD, bad_codes[k]);
    end
    cmp_len(stall_n, 0);
    chk_rd(a1 ^ 16'h0101);
    run(8'h01, 16'h3fff, 8'h7f);
    raw(`FPC_SFR_PKEY, 8'h5a);
    raw(`FPC_SFR_PWE_LO, 8'hfd);
    raw(`FPC_SFR_PRD, 8'hfd);
    run(8'h08, 16'h0000, 8'h00);
    run(8'h01, 16'h0210, 8'h00);
    run(8'h02, 16'h3e00, 8'h00);
    for (k = 0; k < 10; k++) chk_rd(rd_list[k]);
    raw(`FPC_SFR_PKEY, 8'h00);
    raw(`FPC_SFR_PWE_LO, 8'h00);
    run(8'h08, 16'h0000, 8'h00);
    run(8'h01, 16'h0400, 8'h00);
    chk_rd(16'h3ffc);
    chk_rd(16'h0400);
    run(8'h03, 16'h0000, 8'h00);
    chk_rd(16'h3ffa);
    chk_rd(a1 + 16'h0200);
    run(8'h01, 16'h0210, d1);
    chk_rd(16'h0210);
    give_verdict;
  end
endmodule : testbench
